//--- src/sph_cfg.svh
// constants for the speech processor host interface: codes, positions, timing
// assumes a 100 MHz clock; bus bit index i is data line Di (D0 is the MSB)
`ifndef SPH_CFG_SVH
`define SPH_CFG_SVH

`define SPH_CLK_MHZ          100
`define SPH_ROM_BYTE_US      80
`define SPH_BITS_PER_BYTE    8
`define SPH_BRANCH_US        240
`define SPH_FRAME_MS         25
`define SPH_INTERP_PER_FRAME 8

`define SPH_FIFO_SLOTS       5'h10
`define SPH_FIFO_LOW_LIMIT   5'h08
`define SPH_TALK_START_FILL  5'h09

`define SPH_CMD_NOP_A        3'h0
`define SPH_CMD_READ_BYTE    3'h1
`define SPH_CMD_NOP_B        3'h2
`define SPH_CMD_BRANCH       3'h3
`define SPH_CMD_LOAD_ADDR    3'h4
`define SPH_CMD_SPEAK        3'h5
`define SPH_CMD_EXT_SPEECH   3'h6
`define SPH_CMD_RESET        3'h7

`define SPH_BIT_TALK         0
`define SPH_BIT_LOW          1
`define SPH_BIT_EMPTY        2
`define SPH_BIT_CMD_MSB      1
`define SPH_BIT_CMD_MID      2
`define SPH_BIT_CMD_LSB      3
`define SPH_BIT_ADDR_MSB     4
`define SPH_BIT_ADDR_LSB     7

`endif

//--- src/sph_fifo.sv
// speech data fifo: sixteen byte slots, parallel in, serial out
// assumes a byte is held as bus lines D0..D7, so D7 (the lsb) leaves first
`default_nettype none
`include "sph_cfg.svh"
module sph_fifo (
	input  wire logic       clock,
	input  wire logic       rst_b,
	input  wire logic       purge,
	input  wire logic       wr_en,
	input  wire logic [7:0] wr_byte,
	input  wire logic       rd_en,
	output logic            rd_bit,
	output logic [4:0]      count,
	output logic            drained
);
	logic [7:0] slot_reg [16];
	logic [4:0] count_reg;
	logic [2:0] bit_idx_reg;
	logic       drained_reg;

	wire shift_byte = rd_en && count_reg != 5'h0 && bit_idx_reg == 3'h0;
	wire wr_ok      = wr_en && count_reg != `SPH_FIFO_SLOTS;
	// slot just above the newest byte, one lower when the oldest leaves
	wire [3:0] wr_idx = shift_byte ? 4'(count_reg - 5'h1) : count_reg[3:0];

	always_ff @(posedge clock) begin
		if (!rst_b || purge) begin
			count_reg   <= 5'h0;
			bit_idx_reg <= 3'h7;
			drained_reg <= 1'b0;
		end else begin
			drained_reg <= shift_byte && count_reg == 5'h1 && !wr_ok;
			if (rd_en && count_reg != 5'h0)
				bit_idx_reg <= bit_idx_reg - 3'h1;
			count_reg <= count_reg + {4'h0, wr_ok} - {4'h0, shift_byte};
		end
	end

	always_ff @(posedge clock) begin
		for (int i = 0; i < 15; i++) begin
			if (shift_byte)
				slot_reg[i] <= slot_reg[i+1];
		end
		if (wr_ok)
			slot_reg[wr_idx] <= wr_byte;
	end

	assign rd_bit  = slot_reg[0][bit_idx_reg];
	assign count   = count_reg;
	assign drained = drained_reg;
endmodule : sph_fifo
`default_nettype wire

//--- src/sph_host_if.sv
// host interface and command interpreter of the speech processor
// assumes host selects are synchronous and never both low; a bit read
// from the speech rom is sampled at the end of each rom function time
`default_nettype none
`include "sph_cfg.svh"
module sph_host_if #(
	parameter int BRANCH_CYC = `SPH_BRANCH_US * `SPH_CLK_MHZ,
	parameter int INTERP_CYC = (`SPH_FRAME_MS * 1000 * `SPH_CLK_MHZ) / `SPH_INTERP_PER_FRAME
) (
	input  wire logic                clock,
	input  wire logic                rst_b,
	input  wire logic                read_select_n,
	input  wire logic                write_select_n,
	input  wire logic [7:0]          data_in,
	output logic [7:0]               data_out,
	output logic                     data_oe,
	output logic                     ready_n,
	output logic                     int_n,
	output var sph_pkg::sph_rom_bus_t rom_bus,
	input  wire logic                rom_data_in,
	input  wire logic                synth_bit_req,
	output logic                     synth_bit,
	output logic                     synth_bit_valid,
	input  wire logic                stop_code_seen,
	output logic                     frame_tick,
	output logic                     audio_on
);
	localparam int ROM_BIT_CYC = (`SPH_ROM_BYTE_US * `SPH_CLK_MHZ) / `SPH_BITS_PER_BYTE;

	sph_pkg::sph_state_t   state_reg;
	sph_pkg::sph_rom_bus_t rom_bus_reg;
	logic [7:0] command_latch_reg, rom_byte_holding_reg, data_out_reg;
	logic [2:0] bit_cnt_reg, ivl_cnt_reg;
	logic       taken_reg, ready_n_reg, data_oe_reg, int_n_reg;
	logic       cmd_new_reg, dummy_pend_reg, op_live_reg, syn_pend_reg;
	logic       talk_flag_reg, fifo_low_flag_reg, fifo_empty_flag_reg;
	logic       talk_d_reg, low_d_reg, empty_d_reg;
	logic       route_fifo_reg, route_data_reg, byte_ready_reg, ext_wait_reg;
	logic       rom_speak_reg, stop_pend_reg, audio_reg, frame_tick_reg;
	logic       synth_bit_reg, synth_valid_reg;
	logic       tmr_busy, tmr_done, ivl_busy, ivl_done, fifo_bit, fifo_drained;
	logic [4:0] fifo_count;

	// bus decode
	wire sel_r   = !read_select_n && write_select_n;
	wire sel_w   = !write_select_n && read_select_n;
	wire sel_any = sel_r || sel_w;
	wire cmd_busy = cmd_new_reg || state_reg != sph_pkg::ST_IDLE;
	wire rd_take = sel_r && !taken_reg && (!route_data_reg || byte_ready_reg);
	wire wr_take = sel_w && !taken_reg &&
		(route_fifo_reg ? fifo_count != `SPH_FIFO_SLOTS : !cmd_busy);
	wire fifo_wr  = wr_take && route_fifo_reg;
	wire cmd_wr   = wr_take && !route_fifo_reg;
	wire stat_rd  = rd_take && !route_data_reg;
	wire wr_wait  = sel_w && !taken_reg && !wr_take;
	wire [2:0] code_in = {data_in[`SPH_BIT_CMD_MSB], data_in[`SPH_BIT_CMD_MID],
		data_in[`SPH_BIT_CMD_LSB]};
	wire [2:0] cmd_code = {command_latch_reg[`SPH_BIT_CMD_MSB],
		command_latch_reg[`SPH_BIT_CMD_MID], command_latch_reg[`SPH_BIT_CMD_LSB]};
	wire [7:0] status_byte = {5'h0, fifo_empty_flag_reg, fifo_low_flag_reg,
		talk_flag_reg};

	// command dispatch
	wire exec_go     = cmd_new_reg && state_reg == sph_pkg::ST_IDLE;
	wire needs_dummy = dummy_pend_reg && (cmd_code == `SPH_CMD_READ_BYTE ||
		cmd_code == `SPH_CMD_SPEAK || cmd_code == `SPH_CMD_RESET);
	wire exec_now    = exec_go && !needs_dummy;
	wire is_read     = exec_now && cmd_code == `SPH_CMD_READ_BYTE;
	wire is_branch   = exec_now && cmd_code == `SPH_CMD_BRANCH;
	wire is_load     = exec_now && cmd_code == `SPH_CMD_LOAD_ADDR;
	wire is_speak    = exec_now && cmd_code == `SPH_CMD_SPEAK;
	wire is_ext      = exec_now && cmd_code == `SPH_CMD_EXT_SPEECH;
	wire is_reset    = exec_now && cmd_code == `SPH_CMD_RESET;
	wire fifo_purge  = is_ext || is_reset;

	// speech events
	wire fifo_mode = route_fifo_reg && talk_flag_reg && !ext_wait_reg;
	wire fifo_rd   = synth_bit_req && fifo_mode;
	wire ext_fill  = ext_wait_reg && fifo_count >= `SPH_TALK_START_FILL;
	wire ext_abort = fifo_drained && route_fifo_reg;
	wire stop_now  = frame_tick_reg && stop_pend_reg;

	// rom function of each state
	wire rom_state = state_reg != sph_pkg::ST_IDLE;
	wire tmr_start = rom_state && !op_live_reg && !tmr_busy;
	wire fn_a = state_reg == sph_pkg::ST_DUMMY || state_reg == sph_pkg::ST_RST_DUMMY ||
		state_reg == sph_pkg::ST_RDBIT || state_reg == sph_pkg::ST_SYN_BIT ||
		state_reg == sph_pkg::ST_BRANCH;
	wire fn_b = state_reg == sph_pkg::ST_LOAD || state_reg == sph_pkg::ST_RST_LOAD ||
		state_reg == sph_pkg::ST_BRANCH;
	wire [15:0] tmr_load = state_reg == sph_pkg::ST_HOLDOFF ? 16'(BRANCH_CYC) :
		16'(ROM_BIT_CYC);

	sph_timer #(.W(16)) u_rom_tmr (
		.clock    (clock),
		.rst_b    (rst_b),
		.start    (tmr_start),
		.load_val (tmr_load),
		.busy     (tmr_busy),
		.done     (tmr_done)
	);

	// free-running interpolation interval timer
	sph_timer #(.W(20)) u_ivl_tmr (
		.clock    (clock),
		.rst_b    (rst_b),
		.start    (!ivl_busy && !ivl_done),
		.load_val (20'(INTERP_CYC - 2)),
		.busy     (ivl_busy),
		.done     (ivl_done)
	);

	sph_fifo u_fifo (
		.clock   (clock),
		.rst_b   (rst_b),
		.purge   (fifo_purge),
		.wr_en   (fifo_wr),
		.wr_byte (data_in),
		.rd_en   (fifo_rd),
		.rd_bit  (fifo_bit),
		.count   (fifo_count),
		.drained (fifo_drained)
	);

	// host bus handshake
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			taken_reg    <= 1'b0;
			ready_n_reg  <= 1'b0;
			data_oe_reg  <= 1'b0;
			data_out_reg <= 8'h00;
		end else begin
			taken_reg   <= sel_any && (taken_reg || rd_take || wr_take);
			data_oe_reg <= sel_r;
			if (rd_take || wr_take)
				ready_n_reg <= 1'b0;
			else if (sel_any && !taken_reg)
				ready_n_reg <= 1'b1;
			if (rd_take)
				data_out_reg <= route_data_reg ? rom_byte_holding_reg : status_byte;
		end
	end

	always_ff @(posedge clock) begin
		if (cmd_wr)
			command_latch_reg <= data_in;
	end

	// command and rom sequencer; block reset runs the rom init sequence too
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			state_reg      <= sph_pkg::ST_RST_LOAD;
			op_live_reg    <= 1'b0;
			bit_cnt_reg    <= 3'h0;
			cmd_new_reg    <= 1'b0;
			dummy_pend_reg <= 1'b0;
			rom_bus_reg    <= '0;
			syn_pend_reg   <= 1'b0;
		end else begin
			if (cmd_wr)
				cmd_new_reg <= 1'b1;
			else if (exec_now)
				cmd_new_reg <= 1'b0;
			if (tmr_start)
				op_live_reg <= 1'b1;
			else if (tmr_done)
				op_live_reg <= 1'b0;
			if (tmr_start) begin
				rom_bus_reg.rom_ctrl_a <= fn_a;
				rom_bus_reg.rom_ctrl_b <= fn_b;
			end else if (tmr_done) begin
				rom_bus_reg.rom_ctrl_a <= 1'b0;
				rom_bus_reg.rom_ctrl_b <= 1'b0;
			end
			if (is_load)
				rom_bus_reg.rom_nibble <= {command_latch_reg[`SPH_BIT_ADDR_MSB],
					command_latch_reg[5], command_latch_reg[6],
					command_latch_reg[`SPH_BIT_ADDR_LSB]};
			if (synth_bit_req && rom_speak_reg)
				syn_pend_reg <= 1'b1;
			else if (state_reg == sph_pkg::ST_SYN_BIT || is_reset)
				syn_pend_reg <= 1'b0;
			case (state_reg)
			sph_pkg::ST_IDLE: begin
				if (exec_go && needs_dummy) begin
					state_reg      <= sph_pkg::ST_DUMMY;
					dummy_pend_reg <= 1'b0;
				end else if (is_read) begin
					state_reg   <= sph_pkg::ST_RDBIT;
					bit_cnt_reg <= 3'h0;
				end else if (is_branch)
					state_reg <= sph_pkg::ST_BRANCH;
				else if (is_load)
					state_reg <= sph_pkg::ST_LOAD;
				else if (is_reset)
					state_reg <= sph_pkg::ST_RST_LOAD;
				else if (syn_pend_reg && rom_speak_reg && !cmd_new_reg)
					state_reg <= sph_pkg::ST_SYN_BIT;
			end
			sph_pkg::ST_LOAD: begin
				if (tmr_done) begin
					state_reg      <= sph_pkg::ST_IDLE;
					dummy_pend_reg <= 1'b1;
				end
			end
			sph_pkg::ST_RDBIT: begin
				if (tmr_done) begin
					bit_cnt_reg <= bit_cnt_reg + 3'h1;
					if (bit_cnt_reg == 3'h7)
						state_reg <= sph_pkg::ST_IDLE;
				end
			end
			sph_pkg::ST_BRANCH: begin
				if (tmr_done)
					state_reg <= sph_pkg::ST_HOLDOFF;
			end
			sph_pkg::ST_RST_LOAD: begin
				if (tmr_done)
					state_reg <= sph_pkg::ST_RST_DUMMY;
			end
			sph_pkg::ST_RST_DUMMY: begin
				if (tmr_done) begin
					state_reg      <= sph_pkg::ST_IDLE;
					dummy_pend_reg <= 1'b0;
				end
			end
			default: begin
				if (tmr_done)
					state_reg <= sph_pkg::ST_IDLE;
			end
			endcase
		end
	end

	// rom byte assembly: first bit ends in D0, last in D7
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			rom_byte_holding_reg <= 8'h00;
			byte_ready_reg       <= 1'b0;
		end else begin
			if (state_reg == sph_pkg::ST_RDBIT && tmr_done)
				rom_byte_holding_reg <= {rom_data_in, rom_byte_holding_reg[7:1]};
			if (cmd_wr)
				byte_ready_reg <= 1'b0;
			else if (state_reg == sph_pkg::ST_RDBIT && tmr_done && bit_cnt_reg == 3'h7)
				byte_ready_reg <= 1'b1;
		end
	end

	// serial bit feed to the synthesizer
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			synth_bit_reg   <= 1'b0;
			synth_valid_reg <= 1'b0;
		end else begin
			synth_valid_reg <= fifo_rd || (state_reg == sph_pkg::ST_SYN_BIT && tmr_done);
			if (fifo_rd)
				synth_bit_reg <= fifo_bit;
			else if (state_reg == sph_pkg::ST_SYN_BIT && tmr_done)
				synth_bit_reg <= rom_data_in;
		end
	end

	// frame boundaries: eight intervals make one frame
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			ivl_cnt_reg    <= 3'h0;
			frame_tick_reg <= 1'b0;
		end else begin
			if (ivl_done)
				ivl_cnt_reg <= ivl_cnt_reg + 3'h1;
			frame_tick_reg <= ivl_done && ivl_cnt_reg == 3'h7;
		end
	end

	// talk, routing and speech flags; a clear hides a same-cycle set only for talk and audio
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			talk_flag_reg  <= 1'b0;
			audio_reg      <= 1'b0;
			stop_pend_reg  <= 1'b0;
			route_fifo_reg <= 1'b0;
			ext_wait_reg   <= 1'b0;
			rom_speak_reg  <= 1'b0;
			route_data_reg <= 1'b0;
		end else begin
			if (is_reset || ext_abort || stop_now)
				talk_flag_reg <= 1'b0;
			else if (is_speak || ext_fill)
				talk_flag_reg <= 1'b1;
			if (is_reset || ext_abort)
				audio_reg <= 1'b0;
			else if (frame_tick_reg)
				audio_reg <= talk_flag_reg && !stop_pend_reg;
			if (stop_code_seen && talk_flag_reg)
				stop_pend_reg <= 1'b1;
			else if (frame_tick_reg || is_reset || ext_abort)
				stop_pend_reg <= 1'b0;
			if (is_ext)
				route_fifo_reg <= 1'b1;
			else if (ext_abort || stop_now)
				route_fifo_reg <= 1'b0;
			if (is_ext)
				ext_wait_reg <= 1'b1;
			else if (ext_fill || ext_abort)
				ext_wait_reg <= 1'b0;
			if (is_speak)
				rom_speak_reg <= 1'b1;
			else if (is_reset || stop_now)
				rom_speak_reg <= 1'b0;
			if (cmd_wr)
				route_data_reg <= code_in == `SPH_CMD_READ_BYTE;
			else if (rd_take)
				route_data_reg <= 1'b0;
		end
	end

	// fifo status and interrupt line
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			fifo_low_flag_reg   <= 1'b1;
			fifo_empty_flag_reg <= 1'b1;
			talk_d_reg          <= 1'b0;
			low_d_reg           <= 1'b1;
			empty_d_reg         <= 1'b1;
			int_n_reg           <= 1'b1;
		end else begin
			fifo_low_flag_reg <= fifo_count <= `SPH_FIFO_LOW_LIMIT || fifo_purge;
			if (fifo_purge || fifo_drained)
				fifo_empty_flag_reg <= 1'b1;
			else if (fifo_wr)
				fifo_empty_flag_reg <= 1'b0;
			talk_d_reg  <= talk_flag_reg;
			low_d_reg   <= fifo_low_flag_reg;
			empty_d_reg <= fifo_empty_flag_reg;
			if ((talk_d_reg && !talk_flag_reg) || (!low_d_reg && fifo_low_flag_reg) ||
				(!empty_d_reg && fifo_empty_flag_reg))
				int_n_reg <= 1'b0;
			else if (stat_rd || is_reset)
				int_n_reg <= 1'b1;
		end
	end

	assign data_out        = data_out_reg;
	assign data_oe         = data_oe_reg;
	assign ready_n         = ready_n_reg;
	assign int_n           = int_n_reg;
	assign rom_bus         = rom_bus_reg;
	assign synth_bit       = synth_bit_reg;
	assign synth_bit_valid = synth_valid_reg;
	assign frame_tick      = frame_tick_reg;
	assign audio_on        = audio_reg;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	write_ready_a: assert property (wr_take |=> !ready_n)
		else $error("ready not lowered after write latch");
	select_ready_a: assert property (wr_wait |=> ready_n)
		else $error("ready low while write is stalled");
	fifo_route_a: assert property (wr_take && route_fifo_reg |=> fifo_empty_flag_reg == 1'b0 || $past(fifo_purge))
		else $error("fifo write did not reach the fifo");
	status_bits_a: assert property (stat_rd |=> data_out == {5'h0, $past(status_byte[2:0])})
		else $error("status byte layout wrong");
	empty_stop_a: assert property (ext_abort |=> !talk_flag_reg && !route_fifo_reg && fifo_empty_flag_reg)
		else $error("drained fifo did not end external speech");
	low_flag_a: assert property (fifo_count >= `SPH_TALK_START_FILL && !fifo_purge |=> !fifo_low_flag_reg)
		else $error("low flag set with nine bytes held");
	speak_talk_a: assert property (is_speak |=> talk_flag_reg)
		else $error("speak did not raise talk");
	talk_int_a: assert property ($fell(talk_flag_reg) |=> !int_n)
		else $error("talk falling raised no interrupt");
	load_fn_a: assert property (state_reg == sph_pkg::ST_LOAD && op_live_reg |-> rom_bus.rom_ctrl_b && !rom_bus.rom_ctrl_a)
		else $error("load nibble code wrong");
	holdoff_idle_a: assert property (state_reg == sph_pkg::ST_HOLDOFF |-> !rom_bus.rom_ctrl_a && !rom_bus.rom_ctrl_b)
		else $error("rom touched during branch holdoff");
	reset_clear_a: assert property (is_reset |=> !talk_flag_reg && !audio_reg ##1 fifo_count == 5'h0)
		else $error("reset command left speech running");

	read_byte_c: cover property (is_read ##[1:1000] rd_take && route_data_reg);
	ext_talk_c: cover property (is_ext ##[1:1000] ext_fill);
	drain_c: cover property (ext_abort);
	stop_frame_c: cover property (stop_now);
endmodule : sph_host_if
`default_nettype wire

//--- src/sph_pkg.sv
// types shared by the speech processor host interface
// assumes sph_cfg.svh holds all numeric constants
`default_nettype none
package sph_pkg;
	typedef enum logic [3:0] {
		ST_IDLE, ST_LOAD, ST_DUMMY, ST_RDBIT, ST_BRANCH, ST_HOLDOFF,
		ST_RST_LOAD, ST_RST_DUMMY, ST_SYN_BIT
	} sph_state_t;

	typedef struct packed {
		logic       rom_ctrl_a;
		logic       rom_ctrl_b;
		logic [3:0] rom_nibble;
	} sph_rom_bus_t;
endpackage : sph_pkg
`default_nettype wire

//--- src/sph_timer.sv
// one-shot down counter: start loads a count, done pulses when it runs out
// assumes start is only raised while not busy and load_val is at least one
`default_nettype none
module sph_timer #(
	parameter int W = 16
) (
	input  wire logic         clock,
	input  wire logic         rst_b,
	input  wire logic         start,
	input  wire logic [W-1:0] load_val,
	output logic              busy,
	output logic              done
);
	logic [W-1:0] cnt_reg;
	logic         busy_reg;
	logic         done_reg;

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			cnt_reg  <= '0;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			done_reg <= busy_reg && cnt_reg == W'(1);
			if (start) begin
				cnt_reg  <= load_val;
				busy_reg <= 1'b1;
			end else if (busy_reg) begin
				cnt_reg  <= cnt_reg - W'(1);
				busy_reg <= cnt_reg != W'(1);
			end
		end
	end

	assign busy = busy_reg;
	assign done = done_reg;
endmodule : sph_timer
`default_nettype wire

//--- test/sph_host_if_tb.sv
// testbench of the host interface: host model, serial rom model, synth requests
// assumes sph_pkg and the design files are compiled first
`default_nettype none
module sph_host_if_tb;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct {logic [7:0] cmd; logic [1:0] ctl; logic [3:0] nib; logic [7:0] st;} sph_row_t;
	localparam logic [15:0] PAT = 16'h3ac5;
	logic clock, rst_b, rd_n, wr_n, rom_di, sreq, stop_seen, a_q;
	logic [7:0] din, dout, b, c0, rd_fn, g8, ex;
	logic [3:0] ix;
	logic data_oe, ready_n, int_n, sbit, sval, ftick, audio_on;
	sph_pkg::sph_rom_bus_t rom_bus;
	int error_cnt, n_checks, n;
	sph_row_t rows[3] = '{'{8'h00, 2'b00, 4'h0, 8'h06}, '{8'h04, 2'b00, 4'h0, 8'h06},
		'{8'h92, 2'b01, 4'h9, 8'h06}};
	// short branch hold-off and frames keep the run small and let frame logic be reached
	sph_host_if #(.BRANCH_CYC(20), .INTERP_CYC(40)) dut_u (.clock(clock), .rst_b(rst_b),
		.read_select_n(rd_n),
		.write_select_n(wr_n), .data_in(din), .data_out(dout), .data_oe(data_oe),
		.ready_n(ready_n), .int_n(int_n), .rom_bus(rom_bus), .rom_data_in(rom_di),
		.synth_bit_req(sreq), .synth_bit(sbit), .synth_bit_valid(sval),
		.stop_code_seen(stop_seen), .frame_tick(ftick), .audio_on(audio_on));
	sph_host_model host_u (.clock(clock), .ready_n(ready_n), .data_out(dout),
		.read_select_n(rd_n), .write_select_n(wr_n), .data_in(din));
	// rom model: next pattern bit per read function, inverted when not reading
	always @(posedge clock) begin
		a_q <= rom_bus.rom_ctrl_a;
		if (rom_bus.rom_ctrl_a && !a_q)
			rd_fn <= rd_fn + 8'h01;
	end
	assign rom_di = rom_bus.rom_ctrl_a ? PAT[rd_fn[3:0]] : ~PAT[rd_fn[3:0]];
	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %0t byte got %h exp %h", $time, g, e);
		end
	endtask : chk8
	task automatic chk1(input logic g, input logic e);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %0t bit got %b exp %b", $time, g, e);
		end
	endtask : chk1
	task automatic final_report();
		if (error_cnt == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	initial begin
		#400000;
		error_cnt++;
		final_report();
	end
	initial begin
		rst_b = 1'b0; sreq = 1'b0; stop_seen = 1'b0; rd_fn = 8'h00; a_q = 1'b0;
		error_cnt = 0; n_checks = 0;
		repeat (3) @(posedge clock);
		#1 rst_b = 1'b1;
		host_u.rd(b);
		chk8(b, 8'h06);
		chk1(int_n, 1'b1);
		foreach (rows[i]) begin
			host_u.wr(rows[i].cmd);
			repeat (3) @(posedge clock);
			chk8({6'h00, rom_bus.rom_ctrl_a, rom_bus.rom_ctrl_b}, {6'h00, rows[i].ctl});
			if (rows[i].ctl == 2'b01)
				chk8({4'h0, rom_bus.rom_nibble}, {4'h0, rows[i].nib});
			host_u.rd(b);
			chk8(b, rows[i].st);
		end
		c0 = rd_fn;
		host_u.wr(8'h08);
		host_u.rd(b); // early read is stalled until the byte is whole
		for (int i = 0; i < 8; i++) begin
			ix = rd_fn[3:0] - 4'h7 + 4'(i);
			ex[i] = PAT[ix];
		end
		chk8(b, ex);
		chk8(rd_fn - c0, 8'h09);
		host_u.rd(b);
		chk8(b, 8'h06);
		host_u.wr(8'h0a);
		host_u.rd(b);
		chk8(b, 8'h07);
		host_u.wr(8'h0e);
		repeat (5) @(posedge clock);
		chk1(audio_on, 1'b0);
		chk1(int_n, 1'b0);
		host_u.rd(b);
		chk8(b, 8'h06);
		repeat (2) @(posedge clock);
		chk1(int_n, 1'b1);
		host_u.wr(8'h06);
		host_u.rd(b);
		chk8(b, 8'h06);
		for (int k = 0; k < 9; k++) begin
			host_u.wr(k == 0 ? 8'h0e : 8'h30 + 8'(k));
			host_u.rd(b);
			chk8(b, k < 8 ? 8'h02 : 8'h01);
		end
		for (int j = 0; j < 72; j++) begin
			@(posedge clock);
			#1 sreq = 1'b1;
			@(posedge clock);
			#1 sreq = 1'b0;
			n = 0;
			while (sval !== 1'b1 && n < 4) begin
				@(posedge clock);
				#1 n++;
			end
			if (j < 8)
				g8[7 - j] = sbit;
		end
		chk8(g8, 8'h0e);
		repeat (3) @(posedge clock);
		chk1(int_n, 1'b0);
		host_u.rd(b);
		chk8(b, 8'h06);
		host_u.wr(8'h00); // a fifo write would clear empty
		host_u.rd(b);
		chk8(b, 8'h06);
		host_u.wr(8'h0c);
		repeat (3) @(posedge clock);
		chk8({6'h00, rom_bus.rom_ctrl_a, rom_bus.rom_ctrl_b}, 8'h03);
		host_u.wr(8'h0a); // stalls through the branch hold-off
		@(posedge clock);
		#1 stop_seen = 1'b1;
		@(posedge clock);
		#1 stop_seen = 1'b0;
		repeat (700) @(posedge clock);
		chk1(audio_on, 1'b0);
		chk1(int_n, 1'b0);
		host_u.rd(b);
		chk8(b, 8'h06);
		final_report();
	end
endmodule : sph_host_if_tb
`default_nettype wire

//--- test/sph_host_model.sv
// host cpu model: byte reads and writes with wait states on ready_n
// assumes one clock domain and at least one idle cycle between cycles
`default_nettype none
module sph_host_model (
	input  wire logic       clock,
	input  wire logic       ready_n,
	input  wire logic [7:0] data_out,
	output logic            read_select_n,
	output logic            write_select_n,
	output logic [7:0]      data_in
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		read_select_n = 1'b1;
		write_select_n = 1'b1;
		data_in = 8'h5a;
	end
	// ready_n idles low, so the first edge after the select only arms the wait
	task automatic wait_rdy();
		int n;
		n = 0;
		@(posedge clock);
		do begin
			@(posedge clock);
			n++;
		end while (ready_n !== 1'b0 && n < 12000);
	endtask : wait_rdy
	task automatic wr(input logic [7:0] b);
		@(posedge clock);
		#1;
		write_select_n = 1'b0;
		data_in = b;
		wait_rdy();
		#1;
		write_select_n = 1'b1;
		data_in = ~b; // released bus must not show the stale byte
	endtask : wr
	task automatic rd(output logic [7:0] b);
		@(posedge clock);
		#1;
		read_select_n = 1'b0;
		wait_rdy();
		b = data_out;
		#1;
		read_select_n = 1'b1;
	endtask : rd
endmodule : sph_host_model
`default_nettype wire
